// file: acfg_asserts.sv
// Port checks for the converter configuration block.
`timescale 1ns/1ns
module acfg_asserts
(
	// Clock and reset.
	input wire core_clk,
	input wire srst,
	// Bus.
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// Controls.
	input wire trig_a,
	input wire assist_precharge_ff,
	input wire [2:0] hold_en_ff,
	input wire [1:0] accum_en_ff,
	input wire [6:0] trig_sel_a_ff,
	input wire [6:0] trig_sel_b_ff,
	input wire [1:0] active_group_ff,
	input wire dac_sync_en_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	wire ans = !avs_waitrequest;
	wire wr_ans = avs_write && ans;
	read_latency_a: assert property ($rose(avs_read) |-> avs_waitrequest[*3] ##1 ans)
		else $error("read answer latency wrong");
	wait_pulse_a: assert property (ans |=> avs_waitrequest)
		else $error("waitrequest low too long");
	reset_vals_a: assert property (disable iff (1'b0) srst |=> avs_waitrequest && hold_en_ff == 3'h0)
		else $error("outputs not cleared by reset");
	charge_mode_a: assert property (wr_ans && avs_address == 6'h00 |-> assist_precharge_ff == avs_writedata[4])
		else $error("charge mode not applied");
	hold_enable_a: assert property (wr_ans && avs_address == 6'h01 |-> hold_en_ff == avs_writedata[10:8])
		else $error("hold enables not applied");
	accum_sel_a: assert property (wr_ans && avs_address == 6'h02 |-> accum_en_ff == avs_writedata[1:0])
		else $error("accumulate selects not applied");
	trig_sel_a: assert property (wr_ans && avs_address == 6'h03 |-> trig_sel_a_ff == avs_writedata[14:8] && trig_sel_b_ff == avs_writedata[6:0])
		else $error("trigger selects not applied");
	hold_range_a: assert property (avs_read && ans && avs_address == 6'h01 |-> avs_readdata[7:0] >= 8'h0C && avs_readdata[7:0] <= 8'hFC)
		else $error("hold time out of range");
	preempt_b_a: assert property (trig_a && active_group_ff == 2'h2 |-> ##[1:4] active_group_ff == 2'h1)
		else $error("group A did not preempt group B");
	dac_idle_a: assert property (active_group_ff == 2'h0 && $past(active_group_ff) == 2'h0 && !$past(srst) |-> dac_sync_en_ff)
		else $error("sync enable low while idle");
endmodule
bind acfg_top acfg_asserts chk_u (.*);

// file: acfg_defines.vh
// Constants for the converter sampling and assist configuration block.
// Overview of operation
// - Bit 4 of the assist register selects discharge (0) or precharge (1) before sampling.
// - Assist period code 0000 disables assist; 0011/0110/1001/1100/1111 charge 3/6/9/12/15 cycles.
// - The eight-bit hold sample time sets sampling from 12 to 252 converter clock cycles.
// - Each of three hold enable bits turns the dedicated sample-and-hold for one channel pair on.
// - For each of the two extended channels a select bit of 1 enables addition or averaging.
// - Group A and group B start trigger selectors are each seven bits wide.
// - Fourteen conversion-order registers, index 0 to 13, set the conversion sequence; the sequencer ignores them and steps channels 0 to 13 in order.
// - Sampling-state settings exist for channels 0 to 11, extended, temperature and other sources.
// - Unit 2 outputs a synchronous enable that paces D/A data updates away from conversions.
// - A restart channel select bit sits in the group priority control register.
// - A preempted group rescans from the first channel or from the unfinished channel; a C preempted by B, then B by A, resumes from B's saved channel.
// - A higher-priority group trigger stops a lower one; A ranks above B above C.
`ifndef ACFG_DEFINES_VH
`define ACFG_DEFINES_VH
`define ACFG_AW 6
`define ACFG_OFS_ASSIST 6'h00
`define ACFG_OFS_HOLD 6'h01
`define ACFG_OFS_ACCUM 6'h02
`define ACFG_OFS_TRIG 6'h03
`define ACFG_OFS_GPRIO 6'h04
`define ACFG_OFS_STATUS 6'h05
`define ACFG_OFS_ORDER0 6'h10
`define ACFG_OFS_SSTATE0 6'h20
`define ACFG_N_ORDER 14
`define ACFG_N_SSTATE 15
`define ACFG_RST_SSTATE 8'h0D
`define ACFG_RST_HOLDT 8'h0C
`define ACFG_HOLDT_MIN 8'h0C
`define ACFG_HOLDT_MAX 8'hFC
`define ACFG_ASSIST_MODE_BIT 4
`define ACFG_CONV_CYCLES 8'h10
`define ACFG_CHANS 5'h0E
`endif

// file: acfg_ram.v
// Small register-read memory for order and sampling-state entries.
`timescale 1ns/1ns
module acfg_ram
(
	// Clock.
	input wire core_clk,
	// Write port.
	input wire wr_en,
	input wire [4:0] wr_addr,
	input wire [7:0] wr_data,
	// Read port.
	input wire [4:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:31];
	always @(posedge core_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// file: acfg_top.v
// Converter sampling, assist and group priority configuration with Avalon-MM slave.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "acfg_defines.vh"
module acfg_top
(
	// Clock and reset.
	input wire core_clk,
	input wire srst,
	// Avalon-MM slave.
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Group triggers from the same clock domain.
	input wire trig_a,
	input wire trig_b,
	input wire trig_c,
	// Converter controls.
	output reg assist_active_ff,
	output reg assist_precharge_ff,
	output reg sampling_ff,
	output reg [2:0] hold_en_ff,
	output reg [1:0] accum_en_ff,
	output reg [6:0] trig_sel_a_ff,
	output reg [6:0] trig_sel_b_ff,
	output reg [1:0] active_group_ff,
	output reg [3:0] conv_channel_ff,
	output reg dac_sync_en_ff
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ASSIST = 2'h1;
	localparam ST_SAMPLE = 2'h2;
	localparam ST_CONV = 2'h3;
	localparam GRP_NONE = 2'h0;
	localparam GRP_A = 2'h1;
	localparam GRP_B = 2'h2;
	localparam GRP_C = 2'h3;

	reg [4:0] assist_reg_ff;
	reg [7:0] hold_time_ff;
	reg restart_sel_ff;
	reg [1:0] state_ff;
	reg [7:0] cnt_ff;
	reg [3:0] resume_ch_ff;
	reg pend_b_ff;
	reg pend_c_ff;
	reg [1:0] rd_phase_ff;
	reg [31:0] nxt_rdata;
	wire [7:0] ram_q;
	wire [4:0] ram_waddr;
	wire ram_we;
	wire ord_hit;
	wire ss_hit;
	wire [7:0] hold_clamped;
	wire [3:0] assist_cycles;
	wire a_req;
	wire b_req;
	wire c_req;

	// Order entries occupy memory 0..13, sampling states 16..30.
	assign ord_hit = (avs_address >= `ACFG_OFS_ORDER0) &&
		(avs_address < `ACFG_OFS_ORDER0 + `ACFG_N_ORDER);
	assign ss_hit = (avs_address >= `ACFG_OFS_SSTATE0) &&
		(avs_address < `ACFG_OFS_SSTATE0 + `ACFG_N_SSTATE);
	assign ram_we = avs_write && (rd_phase_ff == 2'h0) && (ord_hit || ss_hit);
	assign ram_waddr = ord_hit ? {1'b0, avs_address[3:0]} : {1'b1, avs_address[3:0]};

	acfg_ram u_ram
	(
		.core_clk(core_clk),
		.wr_en(ram_we),
		.wr_addr(ram_waddr),
		.wr_data(avs_writedata[7:0]),
		.rd_addr(ram_waddr),
		.rd_data(ram_q)
	);

	assign hold_clamped = (hold_time_ff < `ACFG_HOLDT_MIN) ? `ACFG_HOLDT_MIN :
		(hold_time_ff > `ACFG_HOLDT_MAX) ? `ACFG_HOLDT_MAX : hold_time_ff;
	// period code decode
	// Listed codes equal their own cycle count; 0000 disables the assist.
	assign assist_cycles = assist_reg_ff[3:0];

	assign a_req = trig_a;
	assign b_req = trig_b || pend_b_ff;
	assign c_req = trig_c || pend_c_ff;

	// Reads take three wait cycles so memory data arrive from a register.
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		case (avs_address)
		`ACFG_OFS_ASSIST: nxt_rdata = {27'h000_0000, assist_reg_ff};
		`ACFG_OFS_HOLD: nxt_rdata = {21'h00_0000, hold_en_ff, hold_clamped};
		`ACFG_OFS_ACCUM: nxt_rdata = {30'h0000_0000, accum_en_ff};
		`ACFG_OFS_TRIG: nxt_rdata = {17'h0_0000, trig_sel_a_ff, 1'b0, trig_sel_b_ff};
		`ACFG_OFS_GPRIO: nxt_rdata = {31'h0000_0000, restart_sel_ff};
		`ACFG_OFS_STATUS: nxt_rdata = {22'h00_0000, state_ff, active_group_ff,
			conv_channel_ff, pend_b_ff, pend_c_ff};
		default: nxt_rdata = (ord_hit || ss_hit) ? {24'h00_0000, ram_q} : 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (srst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			rd_phase_ff <= 2'h0;
			assist_reg_ff <= 5'h00;
			hold_time_ff <= `ACFG_RST_HOLDT;
			hold_en_ff <= 3'h0;
			accum_en_ff <= 2'h0;
			trig_sel_a_ff <= 7'h00;
			trig_sel_b_ff <= 7'h00;
			restart_sel_ff <= 1'b0;
		end
		else
		begin
			avs_waitrequest <= 1'b1;
			if ((avs_read || avs_write) && rd_phase_ff == 2'h0)
				rd_phase_ff <= 2'h1;
			else if (rd_phase_ff == 2'h1)
				rd_phase_ff <= 2'h2;
			else if (rd_phase_ff == 2'h2)
			begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= avs_read ? nxt_rdata : avs_readdata;
				rd_phase_ff <= 2'h3;
			end
			else
				rd_phase_ff <= 2'h0;
			if (avs_write && rd_phase_ff == 2'h0)
			begin
				case (avs_address)
				`ACFG_OFS_ASSIST: assist_reg_ff <= avs_writedata[4:0];
				`ACFG_OFS_HOLD:
				begin
					hold_time_ff <= avs_writedata[7:0];
					hold_en_ff <= avs_writedata[10:8];
				end
				`ACFG_OFS_ACCUM: accum_en_ff <= avs_writedata[1:0];
				`ACFG_OFS_TRIG:
				begin
					trig_sel_b_ff <= avs_writedata[6:0];
					trig_sel_a_ff <= avs_writedata[14:8];
				end
				`ACFG_OFS_GPRIO: restart_sel_ff <= avs_writedata[0];
				default: ;
				endcase
			end
		end
	end

	// Scan sequencer: assist, sample, then a fixed conversion time per channel.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			active_group_ff <= GRP_NONE;
			conv_channel_ff <= 4'h0;
			resume_ch_ff <= 4'h0;
			pend_b_ff <= 1'b0;
			pend_c_ff <= 1'b0;
			assist_active_ff <= 1'b0;
			assist_precharge_ff <= 1'b0;
			sampling_ff <= 1'b0;
			dac_sync_en_ff <= 1'b0;
		end
		else
		begin
			dac_sync_en_ff <= (state_ff == ST_IDLE) || (state_ff == ST_CONV &&
				cnt_ff == 8'h01);
			// discharge or precharge
			// The mode follows the register so it is settled before any assist begins.
			assist_precharge_ff <= assist_reg_ff[`ACFG_ASSIST_MODE_BIT];
			if (a_req && active_group_ff != GRP_A)
			begin
				if (active_group_ff == GRP_B)
					pend_b_ff <= 1'b1;
				if (active_group_ff == GRP_C)
					pend_c_ff <= 1'b1;
				if (active_group_ff != GRP_NONE)
					resume_ch_ff <= restart_sel_ff ? conv_channel_ff : 4'h0;
				active_group_ff <= GRP_A;
				conv_channel_ff <= 4'h0;
				state_ff <= ST_IDLE;
			end
			else if (b_req && active_group_ff == GRP_C)
			begin
				pend_c_ff <= 1'b1;
				resume_ch_ff <= restart_sel_ff ? conv_channel_ff : 4'h0;
				active_group_ff <= GRP_B;
				conv_channel_ff <= 4'h0;
				state_ff <= ST_IDLE;
			end
			else
			begin
				case (state_ff)
				ST_IDLE:
				begin
					if (active_group_ff == GRP_NONE)
					begin
						if (b_req)
						begin
							active_group_ff <= GRP_B;
							pend_b_ff <= 1'b0;
							conv_channel_ff <= pend_b_ff ? resume_ch_ff : 4'h0;
						end
						else if (c_req)
						begin
							active_group_ff <= GRP_C;
							pend_c_ff <= 1'b0;
							conv_channel_ff <= pend_c_ff ? resume_ch_ff : 4'h0;
						end
					end
					else
					begin
						if (assist_cycles != 4'h0)
						begin
							state_ff <= ST_ASSIST;
							cnt_ff <= {4'h0, assist_cycles};
							assist_active_ff <= 1'b1;
						end
						else
						begin
							state_ff <= ST_SAMPLE;
							cnt_ff <= hold_clamped;
							sampling_ff <= 1'b1;
						end
					end
				end
				ST_ASSIST:
				begin
					if (cnt_ff == 8'h01)
					begin
						assist_active_ff <= 1'b0;
						state_ff <= ST_SAMPLE;
						cnt_ff <= hold_clamped;
						sampling_ff <= 1'b1;
					end
					else
						cnt_ff <= cnt_ff - 8'h01;
				end
				ST_SAMPLE:
				begin
					if (cnt_ff == 8'h01)
					begin
						sampling_ff <= 1'b0;
						state_ff <= ST_CONV;
						cnt_ff <= `ACFG_CONV_CYCLES;
					end
					else
						cnt_ff <= cnt_ff - 8'h01;
				end
				ST_CONV:
				begin
					if (cnt_ff == 8'h01)
					begin
						state_ff <= ST_IDLE;
						if ({1'b0, conv_channel_ff} == `ACFG_CHANS - 5'h01)
						begin
							conv_channel_ff <= 4'h0;
							active_group_ff <= GRP_NONE;
						end
						else
							conv_channel_ff <= conv_channel_ff + 4'h1;
					end
					else
						cnt_ff <= cnt_ff - 8'h01;
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// file: tb_top.sv
// Self-checking bench for the converter configuration block.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic core_clk, srst, avs_read, avs_write, trig_a, trig_b, trig_c;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, assist_active_ff, assist_precharge_ff, sampling_ff, dac_sync_en_ff;
	wire [2:0] hold_en_ff;
	wire [1:0] accum_en_ff, active_group_ff;
	wire [6:0] trig_sel_a_ff, trig_sel_b_ff;
	wire [3:0] conv_channel_ff;
	int fail_count, compares;
	logic [31:0] rd;
	logic [3:0] codes [6] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hC, 4'hF};
	acfg_top dut_u (.*);
	task print_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
		begin
			n++;
			if (n > 20)
			begin
				fail_count++;
				print_verdict();
			end
			@(posedge core_clk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task waitg(input logic [1:0] g);
		int n;
		n = 0;
		while (active_group_ff !== g)
		begin
			n++;
			if (n > 5000)
			begin
				fail_count++;
				print_verdict();
			end
			@(posedge core_clk);
		end
	endtask
	task pulse(input logic [2:0] m);
		{trig_a, trig_b, trig_c} <= m;
		@(posedge core_clk);
		{trig_a, trig_b, trig_c} <= 3'b000;
	endtask
	task t_regs;
		bus(0, 6'h01, 32'h0);
		`CHK(rd[7:0], 8'h0C)
		bus(1, 6'h01, 32'h0000_0505);
		bus(0, 6'h01, 32'h0);
		`CHK(rd[10:0], 11'h50C)
		`CHK(hold_en_ff, 3'h5)
		bus(1, 6'h01, 32'h0000_02FF);
		bus(0, 6'h01, 32'h0);
		`CHK(rd[10:0], 11'h2FC)
		bus(1, 6'h03, 32'h0000_7F00);
		`CHK({trig_sel_a_ff, trig_sel_b_ff}, 14'h3F80)
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 6'h02, i);
			`CHK(accum_en_ff, 2'(i))
		end
		$display("test regs done");
	endtask
	task t_mem(input logic [5:0] base, input int n);
		for (int i = 0; i < n; i++)
			bus(1, base + 6'(i), 32'hA0 + i);
		for (int i = 0; i <= n; i++)
		begin
			bus(0, base + 6'(i), 32'h0);
			`CHK(rd, (i < n) ? 32'hA0 + i : 32'h0)
		end
		$display("test memory done");
	endtask
	task t_assist;
		int n, k;
		for (int i = 0; i < 6; i++)
		begin
			bus(1, 6'h00, {27'h0, 1'(i), codes[i]});
			`CHK(assist_precharge_ff, 1'(i))
			`CHK(dac_sync_en_ff, 1'b1)
			pulse(3'b100);
			n = 0;
			k = 0;
			while (assist_active_ff !== 1'b1 && n < 20)
			begin
				n++;
				@(posedge core_clk);
			end
			while (assist_active_ff === 1'b1 && k < 40)
			begin
				k++;
				@(posedge core_clk);
			end
			`CHK(k, int'(codes[i]))
			waitg(2'h0);
		end
		$display("test assist done");
	endtask
	task t_prio;
		logic [3:0] ch;
		for (int s = 1; s >= 0; s--)
		begin
			bus(1, 6'h04, s);
			pulse(3'b010);
			waitg(2'h2);
			repeat (700) @(posedge core_clk);
			ch = conv_channel_ff;
			pulse(3'b100);
			waitg(2'h1);
			waitg(2'h2);
			`CHK(conv_channel_ff, s ? ch : 4'h0)
			waitg(2'h0);
		end
		pulse(3'b001);
		waitg(2'h3);
		pulse(3'b010);
		repeat (8) @(posedge core_clk);
		`CHK(active_group_ff, 2'h2)
		waitg(2'h0);
		$display("test priority done");
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		{srst, avs_read, avs_write, trig_a, trig_b, trig_c} = 6'b100000;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		fail_count = 0;
		compares = 0;
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_mem(6'h10, 14);
		t_mem(6'h20, 15);
		t_assist();
		t_prio();
		print_verdict();
	end
endmodule
